/* logic/gtc_pkg.sv */
// constants and carrier types for the global test and config relocation bank
// assumes a single 200 MHz clock; all resets arrive as synchronous levels
package gtc_pkg;

    // index positions in the global config space
    localparam logic [7:0] IDX_ADDR_LO  = 8'h26;
    localparam logic [7:0] IDX_ADDR_HI  = 8'h27;
    localparam logic [7:0] IDX_NUM_SEL  = 8'h29;
    localparam logic [7:0] IDX_TEST_A   = 8'h2A;
    localparam logic [7:0] IDX_TEST_B   = 8'h2B;
    localparam logic [7:0] IDX_KBD_CTRL = 8'h2C;
    localparam logic [7:0] IDX_TEST_C   = 8'h2D;
    localparam logic [7:0] IDX_TEST_D   = 8'h2E;
    localparam logic [7:0] IDX_TEST_E   = 8'h2F;

    localparam int          NUM_TEST = 6;
    localparam int          KBD_SLOT = 2;
    localparam logic [7:0]  TEST_IDX [NUM_TEST] = '{
        IDX_TEST_A, IDX_TEST_B, IDX_KBD_CTRL, IDX_TEST_C, IDX_TEST_D, IDX_TEST_E
    };

    // reset values
    localparam logic [7:0]  RST_ZERO       = 8'h00;
    localparam logic [7:0]  RST_NUM_LEGACY = 8'h01;
    localparam logic [7:0]  RST_ADDR_LO    = 8'h2E;
    localparam logic [7:0]  RST_ADDR_HI    = 8'h00;
    localparam logic [15:0] RST_CFG_BASE   = {RST_ADDR_HI, RST_ADDR_LO};

    // field positions
    localparam int NUM_SEL_BIT = 0;
    localparam int KBD_RST_BIT = 6;
    localparam int ADDR_A0_BIT = 0;

    // data port sits one byte above the index port
    localparam logic [15:0] DATA_PORT_OFS = 16'h0001;

    // strap synchroniser refill count after a reset
    localparam logic [1:0]  STRAP_SETTLE = 2'h3;
    localparam logic [1:0]  SETTLE_ONE   = 2'h1;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b01,
        ST_RUN    = 2'b10
    } gtc_strap_st_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } gtc_io_req_t;

    typedef struct packed {
        logic vcc_por;
        logic stby_por;
        logic hard;
    } gtc_resets_t;

endpackage

/* logic/gtc_reg8.sv */
// one byte-wide register with its own reset value and a write strobe
// assumes the caller has already merged the applicable resets into i_rst
`timescale 1ns/100ps
`default_nettype none
module gtc_reg8 #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_q
);
    logic [7:0] q_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_r <= RST_VAL;
        end else if (i_we) begin
            q_r <= i_wdata;
        end
    end

    assign o_q = q_r;
endmodule
`default_nettype wire

/* logic/gtc_top.sv */
// global test and config relocation bank behind the config index/data ports
// assumes host cycles are one-clock strobes on I_REF_CLK and the resets are
// synchronous levels from the chip reset controller; the strap is a raw pin
`timescale 1ns/100ps
`default_nettype none
module gtc_top (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_SRST,
    input  wire logic        I_VCC_POR,
    input  wire logic        I_STBY_POR,
    input  wire logic        I_HARD_RST,
    input  wire logic        I_NUM_STRAP,
    input  wire logic        I_CFG_MODE,
    input  wire logic        I_IO_WR,
    input  wire logic        I_IO_RD,
    input  wire logic [15:0] I_IO_ADDR,
    input  wire logic [7:0]  I_IO_WDATA,
    output logic      [7:0]  O_IO_RDATA,
    output logic             O_IO_RVALID,
    output logic             O_IO_CLAIM,
    output logic      [15:0] O_CFG_BASE,
    output logic             O_DEVICE_NUMBERING_SELECT,
    output logic             O_KBD_CORE_RST
);
    gtc_pkg::gtc_io_req_t  req;
    gtc_pkg::gtc_resets_t  rsts;
    assign req.wr    = I_IO_WR;
    assign req.rd    = I_IO_RD;
    assign req.addr  = I_IO_ADDR;
    assign req.wdata = I_IO_WDATA;

    assign rsts.vcc_por  = I_VCC_POR;
    assign rsts.stby_por = I_STBY_POR;
    assign rsts.hard     = I_HARD_RST;

    // reset groups: each register family honours its own set of resets
    logic rst_all;
    logic rst_test;
    logic rst_addr;
    assign rst_all  = I_SRST | rsts.vcc_por | rsts.stby_por | rsts.hard;
    assign rst_test = I_SRST | rsts.vcc_por | rsts.stby_por;
    assign rst_addr = I_SRST | rsts.vcc_por | rsts.hard;

    // port decode against the committed base
    logic [15:0] cfg_base_r;
    logic [15:0] data_port;
    logic        hit_idx;
    logic        hit_data;

    assign data_port = cfg_base_r + gtc_pkg::DATA_PORT_OFS;
    assign hit_idx   = I_CFG_MODE && (req.addr == cfg_base_r);
    assign hit_data  = I_CFG_MODE && (req.addr == data_port);
    assign O_IO_CLAIM = hit_idx | hit_data;

    logic wr_idx;
    logic wr_data;
    logic rd_any;
    assign wr_idx  = req.wr & hit_idx;
    assign wr_data = req.wr & hit_data;
    assign rd_any  = req.rd & (hit_idx | hit_data);

    // index register
    logic [7:0] index_r;
    always_ff @(posedge I_REF_CLK) begin
        if (rst_all) begin
            index_r <= gtc_pkg::RST_ZERO;
        end else if (wr_idx) begin
            index_r <= req.wdata;
        end
    end

    // per-index write strobes
    logic we_lo;
    logic we_hi;
    logic we_num;
    assign we_lo  = wr_data && (index_r == gtc_pkg::IDX_ADDR_LO);
    assign we_hi  = wr_data && (index_r == gtc_pkg::IDX_ADDR_HI);
    assign we_num = wr_data && (index_r == gtc_pkg::IDX_NUM_SEL);

    // test registers, keyboard control among them
    logic [7:0] test_q [gtc_pkg::NUM_TEST];
    logic       we_test [gtc_pkg::NUM_TEST];

    genvar k;
    generate
        for (k = 0; k < gtc_pkg::NUM_TEST; k++) begin : g_test
            assign we_test[k] = wr_data && (index_r == gtc_pkg::TEST_IDX[k]);
            gtc_reg8 #(
                .RST_VAL (gtc_pkg::RST_ZERO)
            ) u_test (
                .i_clk   (I_REF_CLK),
                .i_rst   (rst_test),
                .i_we    (we_test[k]),
                .i_wdata (req.wdata),
                .o_q     (test_q[k])
            );
        end
    endgenerate

    // keyboard core reset is a straight flop output, so it is held without gaps
    assign O_KBD_CORE_RST = test_q[gtc_pkg::KBD_SLOT][gtc_pkg::KBD_RST_BIT];

    // config address bytes; the low byte is only staged until the high byte lands
    logic [7:0] lo_wdata;
    logic [7:0] addr_lo_q;
    logic [7:0] addr_hi_q;

    always_comb begin
        lo_wdata = req.wdata;
        lo_wdata[gtc_pkg::ADDR_A0_BIT] = 1'b0;
    end

    gtc_reg8 #(
        .RST_VAL (gtc_pkg::RST_ADDR_LO)
    ) u_addr_lo (
        .i_clk   (I_REF_CLK),
        .i_rst   (rst_addr),
        .i_we    (we_lo),
        .i_wdata (lo_wdata),
        .o_q     (addr_lo_q)
    );

    gtc_reg8 #(
        .RST_VAL (gtc_pkg::RST_ADDR_HI)
    ) u_addr_hi (
        .i_clk   (I_REF_CLK),
        .i_rst   (rst_addr),
        .i_we    (we_hi),
        .i_wdata (req.wdata),
        .o_q     (addr_hi_q)
    );

    // committing on the high byte keeps a half-written base from ever decoding
    always_ff @(posedge I_REF_CLK) begin
        if (rst_addr) begin
            cfg_base_r <= gtc_pkg::RST_CFG_BASE;
        end else if (we_hi) begin
            cfg_base_r <= {req.wdata, addr_lo_q};
        end
    end

    assign O_CFG_BASE = cfg_base_r;

    // strap pin: three flops, a level counts once the last two agree
    logic strap_s1_r;
    logic strap_s2_r;
    logic strap_s3_r;
    always_ff @(posedge I_REF_CLK) begin
        strap_s1_r <= I_NUM_STRAP;
        strap_s2_r <= strap_s1_r;
        strap_s3_r <= strap_s2_r;
    end

    // strap capture waits for the synchroniser to refill after a reset
    gtc_pkg::gtc_strap_st_t strap_st_r;
    gtc_pkg::gtc_strap_st_t strap_st_nxt;
    logic [1:0]             settle_r;
    logic                   strap_take;

    assign strap_take = (strap_st_r == gtc_pkg::ST_SETTLE) &&
                        (settle_r == gtc_pkg::STRAP_SETTLE) &&
                        (strap_s2_r == strap_s3_r);

    always_comb begin
        strap_st_nxt = strap_st_r;
        unique case (strap_st_r)
            gtc_pkg::ST_SETTLE: begin
                if (strap_take) begin
                    strap_st_nxt = gtc_pkg::ST_RUN;
                end
            end
            gtc_pkg::ST_RUN: begin
                strap_st_nxt = gtc_pkg::ST_RUN;
            end
            default: begin
                strap_st_nxt = gtc_pkg::ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK) begin
        if (rst_all) begin
            strap_st_r <= gtc_pkg::ST_SETTLE;
        end else begin
            strap_st_r <= strap_st_nxt;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (rst_all) begin
            settle_r <= 2'h0;
        end else if (settle_r != gtc_pkg::STRAP_SETTLE) begin
            settle_r <= settle_r + gtc_pkg::SETTLE_ONE;
        end
    end

    // numbering-select: strap load wins over a coincident software write
    logic [7:0] num_r;
    always_ff @(posedge I_REF_CLK) begin
        if (rst_all) begin
            num_r <= gtc_pkg::RST_ZERO;
        end else if (strap_take) begin
            num_r <= strap_s3_r ? gtc_pkg::RST_NUM_LEGACY : gtc_pkg::RST_ZERO;
        end else if (we_num) begin
            num_r <= req.wdata;
        end
    end

    assign O_DEVICE_NUMBERING_SELECT = num_r[gtc_pkg::NUM_SEL_BIT];

    // read path; indexes outside this group read as zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = gtc_pkg::RST_ZERO;
        if (hit_idx) begin
            rd_mux = index_r;
        end else begin
            unique case (index_r)
                gtc_pkg::IDX_ADDR_LO:  rd_mux = addr_lo_q;
                gtc_pkg::IDX_ADDR_HI:  rd_mux = addr_hi_q;
                gtc_pkg::IDX_NUM_SEL:  rd_mux = num_r;
                gtc_pkg::IDX_TEST_A:   rd_mux = test_q[0];
                gtc_pkg::IDX_TEST_B:   rd_mux = test_q[1];
                gtc_pkg::IDX_KBD_CTRL: rd_mux = test_q[2];
                gtc_pkg::IDX_TEST_C:   rd_mux = test_q[3];
                gtc_pkg::IDX_TEST_D:   rd_mux = test_q[4];
                gtc_pkg::IDX_TEST_E:   rd_mux = test_q[5];
                default:               rd_mux = gtc_pkg::RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (rst_all) begin
            O_IO_RDATA  <= gtc_pkg::RST_ZERO;
            O_IO_RVALID <= 1'b0;
        end else begin
            O_IO_RVALID <= rd_any;
            if (rd_any) begin
                O_IO_RDATA <= rd_mux;
            end
        end
    end

    // checks
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_SRST);

    sequence s_hi_write;
        we_hi && !rst_addr;
    endsequence

    sequence s_lo_write;
        we_lo && !we_hi && !rst_addr;
    endsequence

    sequence s_kbd_write;
        we_test[gtc_pkg::KBD_SLOT] && !rst_test;
    endsequence

    a_num_bit_write: assert property (
        (we_num && !strap_take && !rst_all) |=>
            (O_DEVICE_NUMBERING_SELECT == $past(I_IO_WDATA[0])))
        else $error("numbering bit did not follow write");

    a_strap_open_load: assert property (
        (strap_take && !strap_s3_r && !rst_all) |=>
            (num_r == gtc_pkg::RST_ZERO) && (strap_st_r == gtc_pkg::ST_RUN))
        else $error("open strap did not load zero");

    a_strap_tied_load: assert property (
        (strap_take && strap_s3_r && !rst_all) |=>
            (num_r == gtc_pkg::RST_NUM_LEGACY) && O_DEVICE_NUMBERING_SELECT)
        else $error("tied strap did not load one");

    a_num_reset_reload: assert property (
        $fell(rst_all) |-> (strap_st_r == gtc_pkg::ST_SETTLE) ##[3:8]
            (strap_st_r == gtc_pkg::ST_RUN) || (strap_s2_r != strap_s3_r))
        else $error("numbering not reloaded after reset");

    a_kbd_reset_follow: assert property (
        s_kbd_write |=> (O_KBD_CORE_RST == $past(I_IO_WDATA[6])))
        else $error("keyboard reset bit did not follow write");

    a_kbd_hold_steady: assert property (
        (!we_test[gtc_pkg::KBD_SLOT] && !rst_test) |=> $stable(O_KBD_CORE_RST))
        else $error("keyboard reset changed without a write");

    a_test_por_clear: assert property (
        rst_test |=> (test_q[0] == gtc_pkg::RST_ZERO) &&
            (test_q[2] == gtc_pkg::RST_ZERO) && (test_q[5] == gtc_pkg::RST_ZERO))
        else $error("test registers not cleared");

    a_base_even: assert property (
        (cfg_base_r[gtc_pkg::ADDR_A0_BIT] == 1'b0) &&
            (addr_lo_q[gtc_pkg::ADDR_A0_BIT] == 1'b0))
        else $error("config base is odd");

    a_base_commit: assert property (
        s_hi_write |=> (O_CFG_BASE == {$past(I_IO_WDATA), $past(addr_lo_q)}))
        else $error("high byte did not commit base");

    a_lo_staged_only: assert property (
        s_lo_write |=> $stable(O_CFG_BASE) ##1
            (addr_lo_q == {$past(I_IO_WDATA[7:1], 2), 1'b0}) || $past(we_lo) || $past(rst_addr))
        else $error("low byte moved base or was lost");

    a_addr_reset: assert property (
        rst_addr |=> (addr_lo_q == gtc_pkg::RST_ADDR_LO) &&
            (O_CFG_BASE == gtc_pkg::RST_CFG_BASE))
        else $error("address bytes did not reset");

    a_read_back: assert property (
        (rd_any && hit_data && (index_r == gtc_pkg::IDX_NUM_SEL) && !rst_all) |=>
            O_IO_RVALID && (O_IO_RDATA == $past(num_r)))
        else $error("numbering read did not return stored value");

endmodule
`default_nettype wire

/* tb/tb_gtc_top.sv */
// self-checking bench for the global test and config relocation bank
// drives host strobes, resets and the strap pin itself; one clock, no far-side model
`timescale 1ns/100ps
`default_nettype none
module tb_gtc_top;
    logic                 clk;
    logic                 srst;
    gtc_pkg::gtc_resets_t rs;
    logic                 strap;
    logic                 mode;
    gtc_pkg::gtc_io_req_t req;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 claim;
    logic [15:0]          cfg_base;
    logic                 num_sel;
    logic                 kbd_rst;
    logic [15:0]          base;
    logic [7:0]           expq [$];
    logic [7:0]           shadow [gtc_pkg::NUM_TEST];
    int                   errors;
    int                   checks;

    gtc_top u_dut (
        .I_REF_CLK                 (clk),
        .I_SRST                    (srst),
        .I_VCC_POR                 (rs.vcc_por),
        .I_STBY_POR                (rs.stby_por),
        .I_HARD_RST                (rs.hard),
        .I_NUM_STRAP               (strap),
        .I_CFG_MODE                (mode),
        .I_IO_WR                   (req.wr),
        .I_IO_RD                   (req.rd),
        .I_IO_ADDR                 (req.addr),
        .I_IO_WDATA                (req.wdata),
        .O_IO_RDATA                (rdata),
        .O_IO_RVALID               (rvalid),
        .O_IO_CLAIM                (claim),
        .O_CFG_BASE                (cfg_base),
        .O_DEVICE_NUMBERING_SELECT (num_sel),
        .O_KBD_CORE_RST            (kbd_rst)
    );

    always #2.5 clk = ~clk;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one strobe, then an idle edge, so a strobe is never raised and dropped in one step
    task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr, ~wr, a, d};
        @(posedge clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        io(1'b1, base, idx);
        io(1'b1, base + gtc_pkg::DATA_PORT_OFS, d);
    endtask

    task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
        io(1'b1, base, idx);
        expq.push_back(exp);
        io(1'b0, base + gtc_pkg::DATA_PORT_OFS, 8'h00);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (expq.size() != 0) begin
            @(posedge clk);
            n++;
            if (n > 10) begin
                errors++;
                close_out();
            end
        end
    endtask

    task automatic pulse(input gtc_pkg::gtc_resets_t r);
        @(posedge clk);
        rs <= r;
        cyc(2);
        rs <= '0;
    endtask

    // strap needs settle edges plus agreeing sync stages before it shows
    task automatic wait_num(input logic exp);
        int n;
        n = 0;
        cyc(6);
        while (num_sel !== exp) begin
            if (n == 20) begin
                errors++;
                close_out();
            end
            @(posedge clk);
            n++;
        end
        cyc(1);
        chk({15'h0000, num_sel}, {15'h0000, exp});
    endtask

    // every read answer is matched with the oldest note of the driver
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            if (expq.size() == 0) begin
                chk({8'h00, rdata}, 16'hffff);
            end else begin
                chk({8'h00, rdata}, {8'h00, expq.pop_front()});
            end
        end
    end

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        rs = '0;
        strap = 1'b0;
        mode = 1'b1;
        req = '0;
        base = gtc_pkg::RST_CFG_BASE;
        errors = 0;
        checks = 0;
        void'($urandom(32'h6297_c345));
        cyc(6);
        srst <= 1'b0;
        wait_num(1'b0);
        rd_reg(gtc_pkg::IDX_NUM_SEL, gtc_pkg::RST_ZERO);
        rd_reg(gtc_pkg::IDX_ADDR_LO, gtc_pkg::RST_ADDR_LO);
        rd_reg(gtc_pkg::IDX_ADDR_HI, gtc_pkg::RST_ADDR_HI);
        for (int i = 0; i < gtc_pkg::NUM_TEST; i++) begin
            rd_reg(gtc_pkg::TEST_IDX[i], gtc_pkg::RST_ZERO);
        end
        for (int i = 0; i < gtc_pkg::NUM_TEST; i++) begin
            shadow[i] = 8'($urandom);
            // poked to prove storage and reset; the keyboard control slot also drives the core reset from bit 6
            wr_reg(gtc_pkg::TEST_IDX[i], shadow[i]);
        end
        for (int i = 0; i < gtc_pkg::NUM_TEST; i++) begin
            rd_reg(gtc_pkg::TEST_IDX[i], shadow[i]);
        end
        drain();
        chk({15'h0000, kbd_rst}, {15'h0000, shadow[gtc_pkg::KBD_SLOT][gtc_pkg::KBD_RST_BIT]});
        // only the core-reset bit moves; the reserved test bits are written back as they were
        shadow[gtc_pkg::KBD_SLOT][gtc_pkg::KBD_RST_BIT] = 1'b1;
        wr_reg(gtc_pkg::IDX_KBD_CTRL, shadow[gtc_pkg::KBD_SLOT]);
        cyc(5);
        chk({15'h0000, kbd_rst}, 16'h0001);
        shadow[gtc_pkg::KBD_SLOT][gtc_pkg::KBD_RST_BIT] = 1'b0;
        wr_reg(gtc_pkg::IDX_KBD_CTRL, shadow[gtc_pkg::KBD_SLOT]);
        cyc(1);
        chk({15'h0000, kbd_rst}, 16'h0000);
        rd_reg(gtc_pkg::IDX_KBD_CTRL, shadow[gtc_pkg::KBD_SLOT]);
        // outside config state nothing is claimed and writes are dropped
        @(posedge clk);
        mode <= 1'b0;
        wr_reg(gtc_pkg::IDX_TEST_A, ~shadow[0]);
        #1;
        chk({15'h0000, claim}, 16'h0000);
        @(posedge clk);
        mode <= 1'b1;
        rd_reg(gtc_pkg::IDX_TEST_A, shadow[0]);
        wr_reg(8'h28, 8'hff);
        rd_reg(8'h28, 8'h00);
        // relocation: odd low byte, low write alone, then the committing high write
        wr_reg(gtc_pkg::IDX_ADDR_LO, 8'h4f);
        cyc(1);
        chk(cfg_base, gtc_pkg::RST_CFG_BASE);
        rd_reg(gtc_pkg::IDX_ADDR_LO, 8'h4e);
        wr_reg(gtc_pkg::IDX_ADDR_HI, 8'h12);
        req.addr <= 16'h124e;
        #1;
        chk({15'h0000, claim}, 16'h0001);
        chk(cfg_base, 16'h124e);
        base = 16'h124e;
        io(1'b0, gtc_pkg::RST_CFG_BASE + gtc_pkg::DATA_PORT_OFS, 8'h00);
        rd_reg(gtc_pkg::IDX_ADDR_HI, 8'h12);
        drain();
        // hard reset: base and strap reload, test group kept
        @(posedge clk);
        strap <= 1'b1;
        pulse('{1'b0, 1'b0, 1'b1});
        base = gtc_pkg::RST_CFG_BASE;
        cyc(1);
        chk(cfg_base, gtc_pkg::RST_CFG_BASE);
        wait_num(1'b1);
        rd_reg(gtc_pkg::IDX_NUM_SEL, gtc_pkg::RST_NUM_LEGACY);
        rd_reg(gtc_pkg::IDX_TEST_B, shadow[1]);
        // standby reset: test group clears, address bytes kept
        wr_reg(gtc_pkg::IDX_ADDR_LO, 8'h80);
        strap <= 1'b0;
        pulse('{1'b0, 1'b1, 1'b0});
        wait_num(1'b0);
        rd_reg(gtc_pkg::IDX_ADDR_LO, 8'h80);
        rd_reg(gtc_pkg::IDX_TEST_B, gtc_pkg::RST_ZERO);
        // main reset: everything back, strap read again
        wr_reg(gtc_pkg::IDX_TEST_D, 8'h5a);
        strap <= 1'b1;
        pulse('{1'b1, 1'b0, 1'b0});
        wait_num(1'b1);
        rd_reg(gtc_pkg::IDX_ADDR_LO, gtc_pkg::RST_ADDR_LO);
        rd_reg(gtc_pkg::IDX_TEST_D, gtc_pkg::RST_ZERO);
        drain();
        close_out();
    end
endmodule
`default_nettype wire
